// ===== hdl/wfd_top.sv
// Wake frame detector top: registers, frame tracking, four pattern filters
// and the remote-wake scanner. Assumes a byte stream from the MAC receive path,
// with a separate end-of-frame pulse carrying the frame check result.
//
// Contract
// - each filter holds an 8-bit offset of the first CRC byte, byte 0 = destination.
// - each filter stores a 16-bit CRC; equality with frame CRC means wake frame.
// - remote-wake enable suspends normal reception and scans for the remote-wake pattern.
// - a remote-wake detection notifies the host by interrupt or power event line.
// - a remote-wake detection sets the remote-wake-seen status bit.
// - clearing remote-wake enable returns to normal reception.
// - remote-wake checks frames sent to the station address or to broadcast.
// - multicast frames also count when the sixteen address copies are present.
// - after both address fields, search for six all-ones sync bytes.
// - sixteen back-to-back station address copies must follow the sync stream.
// - a broken address run restarts the sync search from that byte.
// - sync and copies may sit anywhere, but copies need the sync directly before.
// - full power obeys the enables; light sleep enables both detectors automatically.
// - pattern enable suspends reception; a match sets pattern-seen; clearing restores reception.
// - four independent filters, each with mask, command, offset and CRC-16.
// - mask bit j includes byte offset+j in the CRC; mask bit 31 is zero.
// - command bit 0 enables a filter; bit 3 picks multicast, else unicast.
`timescale 1ns/1ps
`include "wfd_cfg.svh"

module wfd_top (
	// Clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rstn_in,
	// Register port
	input  wire logic [`WFD_ADDR_W-1:0] reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic [31:0]                 reg_rdata_out,
	// Receive frame stream
	input  wire logic                   rx_valid_in,
	input  wire logic                   rx_first_in,
	input  wire wfd_pkg::wfd_byte_t     rx_data_in,
	input  wire logic                   rx_end_in,
	input  wire logic                   rx_fcs_ok_in,
	// Receive path control and wake notification
	output logic                        rx_normal_en_out,
	output logic                        host_irq_out,
	output logic                        power_event_line_out
);
	// ==========================================================
	// Register state
	logic                         pattern_wake_enable_q;
	logic                         remote_wake_enable_q;
	logic                         light_sleep_state_q;
	logic                         pattern_wake_seen_q;
	logic                         remote_wake_seen_q;
	logic                         irq_sel_q;
	logic                         pme_sel_q;
	logic [`WFD_MASK_W-1:0]       mask_q [`WFD_NFILT];
	logic [31:0]                  cmd_q;
	logic [31:0]                  filter_pattern_offset_q;
	logic [31:0]                  filter_pattern_crc01_q;
	logic [31:0]                  filter_pattern_crc23_q;
	logic [47:0]                  station_q;
	logic [31:0]                  rdata_q;
	logic                         irq_q;
	logic                         pme_q;
	logic                         normal_q;

	// ==========================================================
	// Address decode and read selection
	logic                         wr_ctrl;
	logic                         wr_mask [`WFD_NFILT];
	logic                         wr_cmd;
	logic                         wr_off;
	logic                         wr_crc01;
	logic                         wr_crc23;
	logic                         wr_sta_lo;
	logic                         wr_sta_hi;
	logic [31:0]                  ctrl_view;
	logic [31:0]                  rd_mux;

	assign wr_ctrl   = reg_wr_in && (reg_addr_in == `WFD_A_CTRL);
	assign wr_cmd    = reg_wr_in && (reg_addr_in == `WFD_A_CMD);
	assign wr_off    = reg_wr_in && (reg_addr_in == `WFD_A_OFFSET);
	assign wr_crc01  = reg_wr_in && (reg_addr_in == `WFD_A_CRC01);
	assign wr_crc23  = reg_wr_in && (reg_addr_in == `WFD_A_CRC23);
	assign wr_sta_lo = reg_wr_in && (reg_addr_in == `WFD_A_STA_LO);
	assign wr_sta_hi = reg_wr_in && (reg_addr_in == `WFD_A_STA_HI);

	always_comb begin
		ctrl_view                    = 32'h0;
		ctrl_view[`WFD_B_PAT_EN]     = pattern_wake_enable_q;
		ctrl_view[`WFD_B_REM_EN]     = remote_wake_enable_q;
		ctrl_view[`WFD_B_SLEEP]      = light_sleep_state_q;
		ctrl_view[`WFD_B_PAT_SEEN]   = pattern_wake_seen_q;
		ctrl_view[`WFD_B_REM_SEEN]   = remote_wake_seen_q;
		ctrl_view[`WFD_B_IRQ_SEL]    = irq_sel_q;
		ctrl_view[`WFD_B_PME_SEL]    = pme_sel_q;
	end

	always_comb begin
		case (reg_addr_in)
			`WFD_A_CTRL:   rd_mux = ctrl_view;
			`WFD_A_MASK0:  rd_mux = {1'b0, mask_q[0]};
			`WFD_A_MASK1:  rd_mux = {1'b0, mask_q[1]};
			`WFD_A_MASK2:  rd_mux = {1'b0, mask_q[2]};
			`WFD_A_MASK3:  rd_mux = {1'b0, mask_q[3]};
			`WFD_A_CMD:    rd_mux = cmd_q;
			`WFD_A_OFFSET: rd_mux = filter_pattern_offset_q;
			`WFD_A_CRC01:  rd_mux = filter_pattern_crc01_q;
			`WFD_A_CRC23:  rd_mux = filter_pattern_crc23_q;
			`WFD_A_STA_LO: rd_mux = station_q[31:0];
			`WFD_A_STA_HI: rd_mux = {16'h0, station_q[47:32]};
			default:       rd_mux = 32'h0;
		endcase
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pattern_wake_enable_q <= 1'b0;
			remote_wake_enable_q  <= 1'b0;
			light_sleep_state_q   <= 1'b0;
			irq_sel_q             <= 1'b0;
			pme_sel_q             <= 1'b0;
		end else if (wr_ctrl) begin
			pattern_wake_enable_q <= reg_wdata_in[`WFD_B_PAT_EN];
			remote_wake_enable_q  <= reg_wdata_in[`WFD_B_REM_EN];
			light_sleep_state_q   <= reg_wdata_in[`WFD_B_SLEEP];
			irq_sel_q             <= reg_wdata_in[`WFD_B_IRQ_SEL];
			pme_sel_q             <= reg_wdata_in[`WFD_B_PME_SEL];
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd_q                   <= 32'h0;
			filter_pattern_offset_q <= 32'h0;
			filter_pattern_crc01_q  <= 32'h0;
			filter_pattern_crc23_q  <= 32'h0;
			station_q               <= 48'h0;
		end else begin
			if (wr_cmd)    cmd_q                   <= reg_wdata_in;
			if (wr_off)    filter_pattern_offset_q <= reg_wdata_in;
			if (wr_crc01)  filter_pattern_crc01_q  <= reg_wdata_in;
			if (wr_crc23)  filter_pattern_crc23_q  <= reg_wdata_in;
			if (wr_sta_lo) station_q[31:0]         <= reg_wdata_in;
			if (wr_sta_hi) station_q[47:32]        <= reg_wdata_in[15:0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd_in ? rd_mux : 32'h0;
		end
	end

	// ==========================================================
	// Frame tracking: byte index and destination class
	logic [`WFD_IDX_W-1:0]        idx_q;
	logic [`WFD_IDX_W-1:0]        cur_idx;
	logic                         in_dst;
	logic                         sta_byte_eq;
	logic                         dst_own_q;
	logic                         dst_bcast_q;
	logic                         dst_mcast_q;
	logic                         own_base;
	logic                         bcast_base;

	assign cur_idx     = rx_first_in ? `WFD_IDX_W'(0) : idx_q;
	assign in_dst      = (cur_idx < `WFD_IDX_W'(`WFD_ADDR_BYTES));
	assign sta_byte_eq = (rx_data_in == station_q[{cur_idx[2:0], 3'b000} +: 8]);
	assign own_base    = rx_first_in ? 1'b1 : dst_own_q;
	assign bcast_base  = rx_first_in ? 1'b1 : dst_bcast_q;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			idx_q       <= `WFD_IDX_W'(0);
			dst_own_q   <= 1'b0;
			dst_bcast_q <= 1'b0;
			dst_mcast_q <= 1'b0;
		end else if (rx_valid_in) begin
			// Index saturates so long frames never wrap into the mask window
			idx_q <= (&cur_idx) ? cur_idx : cur_idx + `WFD_IDX_W'(1);
			if (rx_first_in) dst_mcast_q <= rx_data_in[0];
			if (in_dst) begin
				dst_own_q   <= own_base & sta_byte_eq;
				dst_bcast_q <= bcast_base & (rx_data_in == `WFD_SYNC_BYTE);
			end
		end
	end

	// ==========================================================
	// Pattern filters
	logic [`WFD_NFILT-1:0]        crc_match;
	logic [`WFD_NFILT-1:0]        filt_hit;
	logic [15:0]                  crc_expect [`WFD_NFILT];

	assign crc_expect[0] = filter_pattern_crc01_q[15:0];
	assign crc_expect[1] = filter_pattern_crc01_q[31:16];
	assign crc_expect[2] = filter_pattern_crc23_q[15:0];
	assign crc_expect[3] = filter_pattern_crc23_q[31:16];

	genvar gi;
	generate
		for (gi = 0; gi < `WFD_NFILT; gi++) begin : g_filt
			logic cmd_en;
			logic cmd_mcast;
			logic type_ok;

			always_ff @(posedge sys_clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					mask_q[gi] <= `WFD_MASK_W'(0);
				end else if (wr_mask[gi]) begin
					mask_q[gi] <= reg_wdata_in[`WFD_MASK_W-1:0];
				end
			end

			assign wr_mask[gi] = reg_wr_in && (reg_addr_in == (`WFD_A_MASK0 + 8'(4 * gi)));
			assign cmd_en      = cmd_q[gi*`WFD_CMD_STRIDE + `WFD_B_CMD_EN];
			assign cmd_mcast   = cmd_q[gi*`WFD_CMD_STRIDE + `WFD_B_CMD_MCAST];
			assign type_ok     = cmd_mcast ? dst_mcast_q : (dst_own_q & ~dst_mcast_q);
			assign filt_hit[gi] = cmd_en && type_ok && crc_match[gi];

			wfd_pattern_crc u_crc (
				.sys_clk_in    (sys_clk_in),
				.rstn_in       (rstn_in),
				.byte_valid_in (rx_valid_in),
				.first_in      (rx_first_in),
				.idx_in        (cur_idx),
				.byte_in       (rx_data_in),
				.mask_in       (mask_q[gi]),
				.offset_in     (filter_pattern_offset_q[gi*8 +: 8]),
				.expect_in     (crc_expect[gi]),
				.match_out     (crc_match[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Remote-wake scanner
	logic                         remote_found;

	wfd_remote_scan u_remote (
		.sys_clk_in    (sys_clk_in),
		.rstn_in       (rstn_in),
		.byte_valid_in (rx_valid_in),
		.first_in      (rx_first_in),
		.idx_in        (cur_idx),
		.byte_in       (rx_data_in),
		.station_in    (station_q),
		.found_out     (remote_found)
	);

	// ==========================================================
	// Frame verdict and status
	logic                         pattern_active;
	logic                         remote_active;
	logic                         frame_good;
	logic                         pattern_hit;
	logic                         remote_hit;
	logic                         clr_pat;
	logic                         clr_rem;
	logic                         any_seen;

	assign pattern_active = pattern_wake_enable_q | light_sleep_state_q;
	assign remote_active  = remote_wake_enable_q | light_sleep_state_q;
	assign frame_good     = rx_end_in && rx_fcs_ok_in;
	assign pattern_hit    = frame_good && pattern_active && (|filt_hit);
	// Broadcast is a multicast, so own, broadcast and multicast all qualify
	assign remote_hit     = frame_good && remote_active && remote_found &&
	                        (dst_own_q | dst_bcast_q | dst_mcast_q);
	assign clr_pat        = wr_ctrl && reg_wdata_in[`WFD_B_PAT_SEEN];
	assign clr_rem        = wr_ctrl && reg_wdata_in[`WFD_B_REM_SEEN];
	assign any_seen       = pattern_wake_seen_q | remote_wake_seen_q;

	// Write one to clear; a hit in the same cycle wins over the clear
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pattern_wake_seen_q <= 1'b0;
			remote_wake_seen_q  <= 1'b0;
		end else begin
			pattern_wake_seen_q <= (pattern_wake_seen_q & ~clr_pat) | pattern_hit;
			remote_wake_seen_q  <= (remote_wake_seen_q & ~clr_rem) | remote_hit;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_q    <= 1'b0;
			pme_q    <= 1'b0;
			normal_q <= 1'b1;
		end else begin
			irq_q    <= irq_sel_q & any_seen;
			pme_q    <= pme_sel_q & any_seen;
			normal_q <= ~(pattern_active | remote_active);
		end
	end

	assign reg_rdata_out        = rdata_q;
	assign host_irq_out         = irq_q;
	assign power_event_line_out = pme_q;
	assign rx_normal_en_out     = normal_q;
endmodule : wfd_top

// ===== hdl/wfd_cfg.svh
// Constants for the wake frame detector: register map, field positions,
// reset values and frame layout. Assumes byte addresses on a plain register port.
`ifndef WFD_CFG_SVH
`define WFD_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define WFD_ADDR_W          8
`define WFD_A_CTRL          8'h00
`define WFD_A_MASK0         8'h04
`define WFD_A_MASK1         8'h08
`define WFD_A_MASK2         8'h0c
`define WFD_A_MASK3         8'h10
`define WFD_A_CMD           8'h14
`define WFD_A_OFFSET        8'h18
`define WFD_A_CRC01         8'h1c
`define WFD_A_CRC23         8'h20
`define WFD_A_STA_LO        8'h24
`define WFD_A_STA_HI        8'h28

// ==========================================================
// Control and status fields
`define WFD_B_PAT_EN        0
`define WFD_B_REM_EN        1
`define WFD_B_SLEEP         2
`define WFD_B_PAT_SEEN      4
`define WFD_B_REM_SEEN      5
`define WFD_B_IRQ_SEL       8
`define WFD_B_PME_SEL       9
`define WFD_B_CMD_EN        0
`define WFD_B_CMD_MCAST     3
`define WFD_CMD_STRIDE      8

// ==========================================================
// Filters and frame layout
`define WFD_NFILT           4
`define WFD_MASK_W          31
`define WFD_IDX_W           11
`define WFD_ADDR_BYTES      6
`define WFD_PAYLOAD_START   11'h00c
`define WFD_SYNC_LAST       3'h5
`define WFD_REP_LAST        4'hf
`define WFD_SYNC_BYTE       8'hff
`define WFD_CRC_POLY        16'h1021
`define WFD_CRC_INIT        16'hffff

`endif

// ===== hdl/wfd_pkg.sv
// Types shared by the wake frame detector modules.
// Assumes wfd_cfg.svh supplies all numeric constants.
package wfd_pkg;
	typedef enum logic {WFD_SCAN_SYNC, WFD_SCAN_ADDR} wfd_scan_e;
	typedef logic [7:0] wfd_byte_t;
endpackage : wfd_pkg

// ===== hdl/wfd_pattern_crc.sv
// One wake-up pattern filter: CRC-16 over the masked bytes of a frame.
// Assumes the byte index and first-byte flag come from the frame tracker.
`timescale 1ns/1ps
`include "wfd_cfg.svh"

module wfd_pattern_crc (
	// Clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rstn_in,
	// Receive byte stream
	input  wire logic                   byte_valid_in,
	input  wire logic                   first_in,
	input  wire logic [`WFD_IDX_W-1:0]  idx_in,
	input  wire wfd_pkg::wfd_byte_t     byte_in,
	// Filter programming
	input  wire logic [`WFD_MASK_W-1:0] mask_in,
	input  wire logic [7:0]             offset_in,
	input  wire logic [15:0]            expect_in,
	// Result
	output logic                        match_out
);
	logic [15:0]            crc_q;
	logic [15:0]            crc_base;
	logic [15:0]            crc_next;
	logic [`WFD_IDX_W-1:0]  rel;
	logic                   in_window;
	logic                   selected;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int b = 7; b >= 0; b--) begin
			r = (r[15] ^ d[b]) ? ((r << 1) ^ `WFD_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_byte

	// ==========================================================
	// Byte selection by offset and mask
	assign rel       = idx_in - {3'h0, offset_in};
	assign in_window = (idx_in >= {3'h0, offset_in}) && (rel < `WFD_IDX_W'(`WFD_MASK_W));
	assign selected  = byte_valid_in && in_window && mask_in[rel[4:0]];
	assign crc_base  = first_in ? `WFD_CRC_INIT : crc_q;
	assign crc_next  = selected ? crc_byte(crc_base, byte_in) : crc_base;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			crc_q <= `WFD_CRC_INIT;
		end else if (byte_valid_in) begin
			crc_q <= crc_next;
		end
	end

	assign match_out = (crc_q == expect_in);
endmodule : wfd_pattern_crc

// ===== hdl/wfd_remote_scan.sv
// Remote-wake scanner: six all-ones sync bytes, then sixteen station addresses.
// Assumes one byte per valid cycle and a first-byte flag per frame.
`timescale 1ns/1ps
`include "wfd_cfg.svh"

module wfd_remote_scan (
	// Clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   rstn_in,
	// Receive byte stream
	input  wire logic                   byte_valid_in,
	input  wire logic                   first_in,
	input  wire logic [`WFD_IDX_W-1:0]  idx_in,
	input  wire wfd_pkg::wfd_byte_t     byte_in,
	input  wire logic [47:0]            station_in,
	// Result, held until the next frame starts
	output logic                        found_out
);
	wfd_pkg::wfd_scan_e state_q;
	wfd_pkg::wfd_scan_e state_d;
	logic [2:0]         ff_cnt_q;
	logic [2:0]         ff_cnt_d;
	logic [3:0]         rep_q;
	logic [3:0]         rep_d;
	logic [2:0]         pos_q;
	logic [2:0]         pos_d;
	logic               found_q;
	logic               found_d;
	logic               is_sync;
	logic               is_addr;
	logic               scan;
	wfd_pkg::wfd_byte_t expect_byte;

	assign is_sync     = (byte_in == `WFD_SYNC_BYTE);
	assign expect_byte = station_in[{pos_q, 3'b000} +: 8];
	assign is_addr     = (byte_in == expect_byte);
	// Address fields are skipped; the sync may start anywhere after them
	assign scan        = byte_valid_in && !first_in && (idx_in >= `WFD_PAYLOAD_START);

	// ==========================================================
	// Next state
	always_comb begin
		state_d  = state_q;
		ff_cnt_d = ff_cnt_q;
		rep_d    = rep_q;
		pos_d    = pos_q;
		found_d  = found_q;
		if (byte_valid_in && first_in) begin
			state_d  = wfd_pkg::WFD_SCAN_SYNC;
			ff_cnt_d = 3'h0;
			rep_d    = 4'h0;
			pos_d    = 3'h0;
			found_d  = 1'b0;
		end else if (scan && !found_q) begin
			case (state_q)
				wfd_pkg::WFD_SCAN_SYNC: begin
					if (!is_sync) begin
						ff_cnt_d = 3'h0;
					end else if (ff_cnt_q == `WFD_SYNC_LAST) begin
						state_d = wfd_pkg::WFD_SCAN_ADDR;
						rep_d   = 4'h0;
						pos_d   = 3'h0;
					end else begin
						ff_cnt_d = ff_cnt_q + 3'h1;
					end
				end
				wfd_pkg::WFD_SCAN_ADDR: begin
					if (is_addr) begin
						if (pos_q == 3'(`WFD_ADDR_BYTES - 1)) begin
							pos_d = 3'h0;
							if (rep_q == `WFD_REP_LAST) begin
								found_d = 1'b1;
								state_d = wfd_pkg::WFD_SCAN_SYNC;
							end else begin
								rep_d = rep_q + 4'h1;
							end
						end else begin
							pos_d = pos_q + 3'h1;
						end
					end else if (is_sync && rep_q == 4'h0 && pos_q == 3'h0) begin
						// A longer run of sync bytes still leads straight into the addresses
						state_d = wfd_pkg::WFD_SCAN_ADDR;
					end else begin
						// Broken run: this byte may already open a new sync stream
						state_d  = wfd_pkg::WFD_SCAN_SYNC;
						ff_cnt_d = is_sync ? 3'h1 : 3'h0;
					end
				end
				default: begin
					state_d = wfd_pkg::WFD_SCAN_SYNC;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q  <= wfd_pkg::WFD_SCAN_SYNC;
			ff_cnt_q <= 3'h0;
			rep_q    <= 4'h0;
			pos_q    <= 3'h0;
			found_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			ff_cnt_q <= ff_cnt_d;
			rep_q    <= rep_d;
			pos_q    <= pos_d;
			found_q  <= found_d;
		end
	end

	assign found_out = found_q;
endmodule : wfd_remote_scan

// ===== verif/wfd_top_monitor.sv
// Port-level checker for the wake frame detector top.
// Assumes the register map and bit positions of wfd_cfg.svh.
`timescale 1ns/1ps
`include "wfd_cfg.svh"

module wfd_top_monitor (
	// Clock and reset
	input wire logic                   sys_clk_in,
	input wire logic                   rstn_in,
	// Register port
	input wire logic [`WFD_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0]            reg_wdata_in,
	input wire logic                   reg_wr_in,
	input wire logic                   reg_rd_in,
	input wire logic [31:0]            reg_rdata_out,
	// Receive stream and notification
	input wire logic                   rx_valid_in,
	input wire logic                   rx_first_in,
	input wire wfd_pkg::wfd_byte_t     rx_data_in,
	input wire logic                   rx_end_in,
	input wire logic                   rx_fcs_ok_in,
	input wire logic                   rx_normal_en_out,
	input wire logic                   host_irq_out,
	input wire logic                   power_event_line_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire ctl_wr   = reg_wr_in && reg_addr_in == `WFD_A_CTRL;
	wire good_end = rx_end_in && rx_fcs_ok_in;
	wire mask_rd  = reg_rd_in && reg_addr_in inside {`WFD_A_MASK0, `WFD_A_MASK1, `WFD_A_MASK2, `WFD_A_MASK3};

	// ==========================================================
	// Assertions
	a_irq_cause: assert property ($rose(host_irq_out) |-> $past(good_end, 2) || $past(ctl_wr, 2))
		else $error("host irq rose without cause");
	a_pme_cause: assert property ($rose(power_event_line_out) |-> $past(good_end, 2) || $past(ctl_wr, 2))
		else $error("power event rose without cause");
	a_rd_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside read cycle");
	a_mask_top_zero: assert property (mask_rd |=> reg_rdata_out[31] == 1'b0)
		else $error("mask bit 31 read as one");
	a_rx_suspend: assert property (ctl_wr && |reg_wdata_in[2:0] |-> ##[1:2] !rx_normal_en_out)
		else $error("normal reception not suspended");
	a_rx_resume: assert property (ctl_wr && reg_wdata_in[2:0] == 3'h0 |-> ##[1:2] rx_normal_en_out)
		else $error("normal reception not restored");
	a_irq_gated: assert property (ctl_wr && !reg_wdata_in[8] ##1 !ctl_wr |=> !host_irq_out)
		else $error("host irq high while not selected");
	a_reset_state: assert property ($rose(rstn_in) |-> rx_normal_en_out && !host_irq_out && !power_event_line_out)
		else $error("outputs wrong after reset");
	c_irq: cover property ($rose(host_irq_out));
	c_pme: cover property ($rose(power_event_line_out));
	c_susp: cover property ($fell(rx_normal_en_out));
endmodule : wfd_top_monitor

bind wfd_top wfd_top_monitor i_mon (.*);

// ===== verif/wfd_rx_src.sv
// Receive frame source standing in for the MAC receive path.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps

module wfd_rx_src (
	// Clock
	input  wire logic          sys_clk_in,
	// Receive stream towards the detector
	output logic               valid_out,
	output logic               first_out,
	output wfd_pkg::wfd_byte_t data_out,
	output logic               end_out,
	output logic               fcs_ok_out
);
	initial begin
		valid_out = 1'b0;
		first_out = 1'b0;
		data_out = 8'h5a;
		end_out = 1'b0;
		fcs_ok_out = 1'b0;
	end
	task automatic send(input wfd_pkg::wfd_byte_t q[$], input logic ok, input int gap);
		foreach (q[i]) begin
			@(posedge sys_clk_in);
			valid_out <= 1'b1;
			first_out <= (i == 0);
			data_out <= q[i];
			if (gap > 0 && i % 4 == 1) begin
				// Slow source: idle cycle, data lines show garbage
				@(posedge sys_clk_in);
				valid_out <= 1'b0;
				first_out <= 1'b0;
				data_out <= ~q[i];
			end
		end
		@(posedge sys_clk_in);
		valid_out <= 1'b0;
		first_out <= 1'b0;
		data_out <= ~data_out;
		end_out <= 1'b1;
		fcs_ok_out <= ok;
		@(posedge sys_clk_in);
		end_out <= 1'b0;
		fcs_ok_out <= ~ok;
	endtask : send
endmodule : wfd_rx_src

// ===== verif/wfd_top_tb.sv
// Self-checking bench for the wake frame detector top.
// Assumes the partner model drives the receive stream.
`timescale 1ns/1ps
`include "wfd_cfg.svh"

module wfd_top_tb;
	localparam int          NCP [6] = '{16, 16, 15, 16, 16, 15};
	localparam logic [31:0] CTL [6] = '{32'h132, 32'h132, 32'h132, 32'h132, 32'h134, 32'h132};
	localparam logic [5:0]  BC = 6'h02, OK = 6'h37, EXP = 6'h33;
	logic               sys_clk_in, rstn_in, reg_wr, reg_rd, rv, rf, re, rok, nrm, irq, power_event_line;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata, rdata, d, m;
	logic [47:0]        st;
	wfd_pkg::wfd_byte_t rd8;
	wfd_pkg::wfd_byte_t fr[$];
	int                 bad_count, compares;

	wfd_top i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .rx_valid_in(rv), .rx_first_in(rf),
		.rx_data_in(rd8), .rx_end_in(re), .rx_fcs_ok_in(rok), .rx_normal_en_out(nrm), .host_irq_out(irq),
		.power_event_line_out(power_event_line));
	wfd_rx_src i_src (.sys_clk_in(sys_clk_in), .valid_out(rv), .first_out(rf), .data_out(rd8), .end_out(re),
		.fcs_ok_out(rok));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Destination, source, two filler bytes, sync stream, then ncp address copies
	task automatic mk(input logic bc, input int ncp);
		fr = {};
		for (int i = 0; i < 6; i++)
			fr.push_back(bc ? 8'hff : st[8*i +: 8]);
		repeat (8) fr.push_back(8'($urandom));
		repeat (6) fr.push_back(8'hff);
		repeat (ncp) for (int i = 0; i < 6; i++) fr.push_back(st[8*i +: 8]);
		fr.push_back(8'h00);
	endtask : mk
	function automatic logic [15:0] crc16(input logic [30:0] mk_bits);
		logic [15:0] c;
		c = `WFD_CRC_INIT;
		for (int j = 0; j < 31; j++)
			if (mk_bits[j])
				for (int b = 7; b >= 0; b--)
					c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[12+j][b]) ? `WFD_CRC_POLY : 16'h0);
		return c;
	endfunction : crc16
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// ==========================================================
	// Stimulus
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		bad_count++;
		conclude();
	end
	initial begin
		{rstn_in, reg_wr, reg_rd, reg_addr, reg_wdata, bad_count, compares} = '0;
		void'($urandom(30106));
		repeat (20) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		st = 48'({$urandom, $urandom}) & 48'hffff_ffff_fffe;
		wr(`WFD_A_STA_LO, st[31:0]);
		wr(`WFD_A_STA_HI, {16'h0, st[47:32]});
		rd(`WFD_A_STA_HI, d);
		chk(d, {16'h0, st[47:32]});
		rd(8'h30, d);
		chk(d, 32'h0);
		wr(`WFD_A_MASK1, 32'hffff_ffff);
		rd(`WFD_A_MASK1, d);
		chk(d, 32'h7fff_ffff);
		for (int k = 0; k < 6; k++) begin
			wr(`WFD_A_CTRL, CTL[k]);
			repeat (2) @(posedge sys_clk_in);
			chk({31'h0, nrm}, 32'h0);
			mk(BC[k], NCP[k]);
			if (k == 5) begin
				// Multicast frame: broken run, then a fresh sync stream and sixteen copies
				fr[0] |= 8'h01;
				repeat (6) fr.push_back(8'hff);
				repeat (16) for (int i = 0; i < 6; i++) fr.push_back(st[8*i +: 8]);
			end
			i_src.send(fr, OK[k], k);
			rd(`WFD_A_CTRL, d);
			chk(d & 32'h337, (CTL[k] & 32'h307) | {26'h0, EXP[k], 5'h0});
			chk({31'h0, irq}, {31'h0, EXP[k]});
		end
		m = ($urandom & 32'h000f_ffff) | 32'h1;
		mk(1'b0, 0);
		repeat (20) fr.push_back(8'($urandom));
		wr(`WFD_A_MASK0, m);
		wr(`WFD_A_OFFSET, 32'h0000_000c);
		wr(`WFD_A_CRC01, {16'h0, crc16(m[30:0])});
		wr(`WFD_A_CMD, 32'h0000_0001);
		rd(`WFD_A_OFFSET, d);
		chk(d, 32'h0000_000c);
		rd(`WFD_A_CRC01, d);
		chk(d, {16'h0, crc16(m[30:0])});
		for (int k = 0; k < 4; k++) begin
			wr(`WFD_A_CTRL, 32'h0000_0231);
			i_src.send(fr, 1'b1, 0);
			rd(`WFD_A_CTRL, d);
			chk(d & 32'h10, k % 3 ? 32'h0 : 32'h10);
			chk({31'h0, power_event_line}, k % 3 ? 32'h0 : 32'h1);
			// k1: corrupt first masked byte; k2: multicast-only filter, unicast frame; k3: multicast frame
			if (k < 2) fr[12] ^= 8'h01;
			if (k == 1) wr(`WFD_A_CMD, 32'h0000_0009);
			if (k == 2) fr[0] |= 8'h01;
		end
		wr(`WFD_A_CTRL, 32'h0000_0030);
		repeat (2) @(posedge sys_clk_in);
		chk({31'h0, nrm}, 32'h1);
		conclude();
	end
endmodule : wfd_top_tb
